/* File: fmbd_cfg.svh */
`ifndef FMBD_CFG_SVH
`define FMBD_CFG_SVH
`define FMBD_ADDR_W 16
`define FMBD_USER_TOP 16'hF7FF
`define FMBD_FW_BASE 16'hF800
`define FMBD_PAGE_W 9
`define FMBD_ERASED_BYTE 8'hFF
`define FMBD_CAL_WORDS 4
`define FMBD_CAL_BASE 16'hFF00
`define FMBD_SRC_NONE 2'h0
`define FMBD_SRC_UART 2'h1
`define FMBD_SRC_I2C 2'h2
`define FMBD_SRC_JTAG 2'h3
`endif

/* File: fmbd_pkg.sv */
package fmbd_pkg;
  typedef enum logic [1:0] {
    FMBD_OP_READ,
    FMBD_OP_PROG,
    FMBD_OP_ERASE
  } fmbd_op_e;
  typedef struct packed {
    logic valid;
    fmbd_op_e op;
    logic [15:0] addr;
    logic [7:0] data;
  } fmbd_req_s;
  typedef struct packed {
    logic done;
    logic err;
    logic [7:0] rdata;
  } fmbd_rsp_s;
endpackage

/* File: fmbd_mem.sv */
`timescale 1ns/1ps
`include "fmbd_cfg.svh"
module fmbd_mem #(
  parameter int AW = 16
) (
  input wire logic clk_sys_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem_q [0:(1<<AW)-1];
  // The calibration words sit where no port may write, so the array stays open to other loaders.
  always @(posedge clk_sys_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    rdata_o <= mem_q[raddr_i];
  end
endmodule

/* File: fmbd_top.sv */
`timescale 1ns/1ps
`include "fmbd_cfg.svh"
// Behaviour
// R1: 64 kB: 62 kB user, 2 kB firmware.
// R2: Firmware region hidden from user accesses.
// R3: Power-on routine loads calibration before user.
// R4: Byte programming only into erased locations.
// R5: Erase works on whole pages only.
// R6: Boot-select low at reset enters download.
// R7: Download may write whole user region.
// R8: Download accepts UART or I2C traffic.
// R9: JTAG also loads code and debugs.
// R10: Boot-select high runs user code.
module fmbd_top #(
  parameter int AW = `FMBD_ADDR_W,
  parameter int PAGE_W = `FMBD_PAGE_W,
  parameter int CAL_N = `FMBD_CAL_WORDS
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic boot_select_pin_i,
  input wire fmbd_pkg::fmbd_req_s user_req_i,
  input wire fmbd_pkg::fmbd_req_s uart_req_i,
  input wire fmbd_pkg::fmbd_req_s i2c_req_i,
  input wire fmbd_pkg::fmbd_req_s jtag_req_i,
  output fmbd_pkg::fmbd_rsp_s rsp_o,
  output logic [1:0] active_src_o,
  output logic download_mode_o,
  output logic user_run_o,
  output logic cal_valid_o,
  output logic [CAL_N*8-1:0] cal_data_o
);
  typedef enum logic [2:0] {
    ST_RESET,
    ST_CAL,
    ST_CAL_WAIT,
    ST_DOWNLOAD,
    ST_USER,
    ST_ERASE
  } fmbd_state_e;

  fmbd_state_e state_q;
  logic dl_q;
  logic [$clog2(CAL_N+1)-1:0] cal_cnt_q;
  logic [PAGE_W-1:0] er_cnt_q;
  logic [AW-1:0] er_base_q;
  logic mem_we;
  logic [AW-1:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [AW-1:0] mem_raddr;
  logic [7:0] mem_rdata;
  fmbd_pkg::fmbd_req_s req;
  logic [1:0] src;
  logic in_user;
  logic prog_ok;
  logic rd_pend_q;
  logic pr_pend_q;
  logic [AW-1:0] pr_addr_q;
  logic [7:0] pr_data_q;

  // Arbitration: downloads only in download mode; JTAG always as an alternative path.
  always_comb begin
    req = '0;
    src = `FMBD_SRC_NONE;
    if (jtag_req_i.valid) begin
      req = jtag_req_i; // [R9]
      src = `FMBD_SRC_JTAG;
    end else if (dl_q && uart_req_i.valid) begin
      req = uart_req_i; // [R8]
      src = `FMBD_SRC_UART;
    end else if (dl_q && i2c_req_i.valid) begin
      req = i2c_req_i; // [R8]
      src = `FMBD_SRC_I2C;
    end else if (!dl_q && user_req_i.valid) begin
      req = user_req_i;
      src = `FMBD_SRC_NONE;
    end
  end

  // Every outside path sees only the user region; firmware stays hidden.
  assign in_user = req.addr <= `FMBD_USER_TOP; // [R1] [R2] [R7]
  assign prog_ok = mem_rdata == `FMBD_ERASED_BYTE; // [R4]

  logic accept;
  assign accept = req.valid && (state_q == ST_DOWNLOAD || state_q == ST_USER)
    && !rd_pend_q && !pr_pend_q;

  // The boot pin is caught on the first clock after reset is released.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      state_q <= ST_RESET;
      dl_q <= 1'b0;
      cal_cnt_q <= '0;
      er_cnt_q <= '0;
      er_base_q <= '0;
    end else begin
      case (state_q)
        ST_RESET: begin
          dl_q <= !boot_select_pin_i; // [R6] [R10]
          state_q <= ST_CAL;
          cal_cnt_q <= '0;
        end
        ST_CAL: begin
          state_q <= ST_CAL_WAIT; // [R3]
        end
        ST_CAL_WAIT: begin
          if (cal_cnt_q == CAL_N[$bits(cal_cnt_q)-1:0] - 1'b1) begin
            state_q <= dl_q ? ST_DOWNLOAD : ST_USER; // [R6] [R10]
          end else begin
            state_q <= ST_CAL;
          end
          cal_cnt_q <= cal_cnt_q + 1'b1;
        end
        ST_DOWNLOAD, ST_USER: begin
          if (accept && req.op == fmbd_pkg::FMBD_OP_ERASE && in_user) begin
            er_base_q <= {req.addr[AW-1:PAGE_W], {PAGE_W{1'b0}}}; // [R5]
            er_cnt_q <= '0;
            state_q <= ST_ERASE;
          end
        end
        ST_ERASE: begin
          er_cnt_q <= er_cnt_q + 1'b1;
          if (&er_cnt_q) begin
            state_q <= dl_q ? ST_DOWNLOAD : ST_USER;
          end
        end
        default: state_q <= ST_RESET;
      endcase
    end
  end

  // Programs read first, then write only if the byte is still erased.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      rd_pend_q <= 1'b0;
      pr_pend_q <= 1'b0;
      pr_addr_q <= '0;
      pr_data_q <= '0;
    end else begin
      rd_pend_q <= accept && in_user && req.op == fmbd_pkg::FMBD_OP_READ;
      pr_pend_q <= accept && in_user && req.op == fmbd_pkg::FMBD_OP_PROG;
      if (accept) begin
        pr_addr_q <= req.addr;
        pr_data_q <= req.data;
      end
    end
  end

  always_comb begin
    mem_we = 1'b0;
    mem_waddr = pr_addr_q;
    mem_wdata = pr_data_q;
    if (state_q == ST_ERASE) begin
      mem_we = 1'b1;
      mem_waddr = er_base_q | {{(AW-PAGE_W){1'b0}}, er_cnt_q}; // [R5]
      mem_wdata = `FMBD_ERASED_BYTE;
    end else if (pr_pend_q && prog_ok) begin
      mem_we = 1'b1; // [R4]
    end
  end

  always_comb begin
    if (state_q == ST_CAL) begin
      mem_raddr = `FMBD_CAL_BASE + {{(AW-$bits(cal_cnt_q)){1'b0}}, cal_cnt_q}; // [R3]
    end else if (accept) begin
      mem_raddr = req.addr;
    end else begin
      mem_raddr = pr_addr_q;
    end
  end

  fmbd_mem #(
    .AW(AW)
  ) u_mem (
    .clk_sys_i(clk_sys_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .raddr_i(mem_raddr),
    .rdata_o(mem_rdata)
  );

  // Calibration words are shifted in before user code is released.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      cal_data_o <= '0;
      cal_valid_o <= 1'b0;
    end else begin
      if (state_q == ST_CAL_WAIT) begin
        cal_data_o <= {mem_rdata, cal_data_o[CAL_N*8-1:8]}; // [R3]
        if (cal_cnt_q == CAL_N[$bits(cal_cnt_q)-1:0] - 1'b1) begin
          cal_valid_o <= 1'b1;
        end
      end
    end
  end

  // Out-of-region requests answer at once with an error and no data.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      rsp_o <= '0;
      active_src_o <= `FMBD_SRC_NONE;
    end else begin
      rsp_o <= '0;
      if (accept) begin
        active_src_o <= src;
      end
      if (accept && !in_user) begin
        rsp_o.done <= 1'b1; // [R2]
        rsp_o.err <= 1'b1;
      end else if (rd_pend_q) begin
        rsp_o.done <= 1'b1;
        rsp_o.rdata <= mem_rdata;
      end else if (pr_pend_q) begin
        rsp_o.done <= 1'b1;
        rsp_o.err <= !prog_ok; // [R4]
      end else if (state_q == ST_ERASE && &er_cnt_q) begin
        rsp_o.done <= 1'b1;
      end
    end
  end

  assign download_mode_o = state_q == ST_DOWNLOAD || (state_q == ST_ERASE && dl_q);
  assign user_run_o = state_q == ST_USER || (state_q == ST_ERASE && !dl_q); // [R10]
endmodule

/* File: fmbd_monitor.sv */
`timescale 1ns/1ps
`include "fmbd_cfg.svh"
module fmbd_monitor #(
  parameter int CAL_N = 4
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire fmbd_pkg::fmbd_rsp_s rsp_o,
  input wire logic [1:0] active_src_o,
  input wire logic download_mode_o,
  input wire logic user_run_o,
  input wire logic cal_valid_o,
  input wire logic [CAL_N*8-1:0] cal_data_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  a_mode_excl: assert property (!(download_mode_o && user_run_o))
    else $error("both modes high");
  a_boot_order: assert property ($rose(reset_n_i) |->
    (!download_mode_o && !user_run_o) [*8] ##[1:4] (download_mode_o || user_run_o))
    else $error("mode not after calibration");
  a_cal_first: assert property ((download_mode_o || user_run_o) |-> cal_valid_o)
    else $error("mode before calibration");
  a_cal_hold: assert property (cal_valid_o && $past(cal_valid_o) |-> $stable(cal_data_o))
    else $error("calibration changed");
  a_dl_hold: assert property (download_mode_o |=> download_mode_o)
    else $error("download mode dropped");
  a_run_hold: assert property (user_run_o |=> user_run_o)
    else $error("user run dropped");
  a_err_done: assert property (rsp_o.err |-> rsp_o.done)
    else $error("error without done");
  a_done_pulse: assert property (rsp_o.done |=> !rsp_o.done)
    else $error("done longer than a cycle");
  a_serial_src: assert property (active_src_o inside {2'h1, 2'h2} |-> download_mode_o)
    else $error("serial taken outside download");
endmodule

/* File: fmbd_host.sv */
`timescale 1ns/1ps
module fmbd_host (
  input wire logic clk_sys_i,
  output fmbd_pkg::fmbd_req_s [3:0] req_o
);
  initial req_o = '0;
  // Lines are inverted on release so a stale address is never mistaken for a request.
  task automatic send(input logic [1:0] s, input logic [1:0] op, input logic [15:0] a,
    input logic [7:0] d);
    @(posedge clk_sys_i);
    req_o[s] <= '{1'b1, fmbd_pkg::fmbd_op_e'(op), a, d};
    @(posedge clk_sys_i);
    req_o[s] <= '{1'b0, fmbd_pkg::fmbd_op_e'(op), ~a, ~d};
  endtask
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic pin = 1'b0;
  fmbd_pkg::fmbd_req_s [3:0] req;
  fmbd_pkg::fmbd_rsp_s rsp;
  fmbd_pkg::fmbd_rsp_s r;
  logic [1:0] src;
  logic dl;
  logic run;
  logic calv;
  logic [31:0] cal;
  logic got;
  int errors = 0;
  int total_checks = 0;
  initial forever #5 clk_sys_i = ~clk_sys_i;
  fmbd_top i_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .boot_select_pin_i(pin),
    .user_req_i(req[0]), .uart_req_i(req[1]), .i2c_req_i(req[2]), .jtag_req_i(req[3]),
    .rsp_o(rsp), .active_src_o(src), .download_mode_o(dl), .user_run_o(run),
    .cal_valid_o(calv), .cal_data_o(cal));
  fmbd_host i_host (.clk_sys_i(clk_sys_i), .req_o(req));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic boot(input logic p);
    @(posedge clk_sys_i);
    reset_n_i <= 1'b0;
    pin <= p;
    repeat (20) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 40 && dl !== 1'b1 && run !== 1'b1; i++) @(negedge clk_sys_i);
    chk("download", {31'h0, !p}, {31'h0, dl});
    chk("run", {31'h0, p}, {31'h0, run});
    chk("cal valid", 1, {31'h0, calv});
    chk("cal", 32'h33323130, cal);
    if (dl !== 1'b1 && run !== 1'b1) begin
      errors++;
      tally_and_finish();
    end
  endtask
  task automatic xfer(input logic [1:0] s, input logic [1:0] op, input logic [15:0] a,
    input logic [7:0] d, input logic ee, input logic [7:0] er);
    got = 1'b0;
    i_host.send(s, op, a, d);
    for (int i = 0; i < 600 && !got; i++) begin
      @(negedge clk_sys_i);
      got = rsp.done;
      r = rsp;
    end
    chk("done", 1, {31'h0, got});
    if (got !== 1'b1) tally_and_finish();
    chk("err", {31'h0, ee}, {31'h0, r.err});
    if (op == 2'h0 && !ee) chk("rdata", {24'h0, er}, {24'h0, r.rdata});
  endtask
  task automatic refuse(input logic [1:0] s);
    i_host.send(s, 2'h0, 16'h0205, 8'h00);
    repeat (6) begin
      @(negedge clk_sys_i);
      chk("refused", 0, {31'h0, rsp.done});
    end
  endtask
  task automatic t_download();
    i_dut.u_mem.mem_q[16'h0205] = 8'h00;
    i_dut.u_mem.mem_q[16'h03FF] = 8'h00;
    i_dut.u_mem.mem_q[16'h0400] = 8'h00;
    for (int k = 0; k < 4; k++) i_dut.u_mem.mem_q[16'hFF00 + k] = 8'(8'h30 + k);
    boot(1'b0);
    refuse(2'h0);
    xfer(2'h1, 2'h1, 16'h0205, 8'hA5, 1'b1, 8'h00);
    xfer(2'h1, 2'h2, 16'h0205, 8'h00, 1'b0, 8'h00);
    xfer(2'h1, 2'h0, 16'h03FF, 8'h00, 1'b0, 8'hFF);
    xfer(2'h1, 2'h0, 16'h0400, 8'h00, 1'b0, 8'h00);
    xfer(2'h1, 2'h1, 16'h0205, 8'hA5, 1'b0, 8'h00);
    xfer(2'h2, 2'h1, 16'h0205, 8'h5A, 1'b1, 8'h00);
    xfer(2'h2, 2'h0, 16'h0205, 8'h00, 1'b0, 8'hA5);
    chk("source", 32'h2, {30'h0, src});
    xfer(2'h3, 2'h2, 16'hF7FF, 8'h00, 1'b0, 8'h00);
    xfer(2'h1, 2'h1, 16'hF7FF, 8'h11, 1'b0, 8'h00);
    xfer(2'h3, 2'h0, 16'hF7FF, 8'h00, 1'b0, 8'h11);
    chk("source", 32'h3, {30'h0, src});
    xfer(2'h3, 2'h0, 16'hF800, 8'h00, 1'b1, 8'h00);
    xfer(2'h1, 2'h1, 16'hFF00, 8'h00, 1'b1, 8'h00);
    $display("download test done");
  endtask
  task automatic t_user();
    boot(1'b1);
    xfer(2'h0, 2'h0, 16'h0205, 8'h00, 1'b0, 8'hA5);
    xfer(2'h0, 2'h0, 16'hF800, 8'h00, 1'b1, 8'h00);
    refuse(2'h1);
    $display("user test done");
  endtask
  initial begin
    t_download();
    t_user();
    tally_and_finish();
  end
endmodule
bind fmbd_top fmbd_monitor #(.CAL_N(CAL_N)) i_mon (.clk_sys_i(clk_sys_i),
  .reset_n_i(reset_n_i), .rsp_o(rsp_o), .active_src_o(active_src_o),
  .download_mode_o(download_mode_o), .user_run_o(user_run_o), .cal_valid_o(cal_valid_o),
  .cal_data_o(cal_data_o));
